// file: dmac_channel.sv
// One DMA channel: APB registers, trigger and chaining control, byte mover sequencing and interrupt flags.
//
// Notes on behaviour
// - Busy reads one while the channel is enabled or a move is still in flight.
// - Direction bit picks the lower-priority neighbour when set, higher-priority when clear.
// - Direction bit matters only while chain allow is one.
// - Enable bit, reset zero, switches the channel on and off.
// - Start and abort events count while disabled only if allow-events bit is set.
// - A neighbour's completion enables this channel only when chain allow is one.
// - Without auto re-enable, block completion clears the enable bit.
// - Event detected is read-only, set by a recorded start event, reset zero.
// - Two-bit priority, code three highest, code zero lowest, drives the arbiter.
// - Clearing enable lets the move in flight finish; busy stays until then.
// - Destination done flag sets when destination pointer reaches destination size.
// - Destination half flag sets when destination pointer reaches half the size.
// - Block complete sets after the larger size in bytes, or on pattern match.
// - Cell complete sets after cell size bytes moved for one trigger.
// - A selected abort event aborts the transfer and sets the abort flag.
// - Address error flag sets when a source or destination address is invalid.
// - Each register has clear, set and invert aliases at plus 4, 8 and 12.
// - Unimplemented control bits read zero and ignore writes.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "dmac_consts.svh"

module dmac_channel
  import dmac_pkg::*;
#(
  parameter int SZ_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_event,
  input wire logic abort_event,
  input wire logic chain_from_lower_done,
  input wire logic chain_from_higher_done,
  input wire dmac_move_rsp_t move_rsp,
  output dmac_move_req_t move_req,
  output logic [1:0] channel_priority,
  output logic channel_busy,
  output logic block_done_pulse,
  output logic irq
);

  // Register state.
  dmac_ctl_t ctl_ff;
  logic busy_ff;
  logic edet_ff;
  logic [`DMAC_INT_W-1:0] flags_ff;
  logic [`DMAC_INT_W-1:0] mask_ff;
  logic pat_en_ff;
  logic [SZ_W-1:0] src_size_ff;
  logic [SZ_W-1:0] dst_size_ff;
  logic [SZ_W-1:0] cell_size_ff;
  logic [SZ_W-1:0] src_ptr_ff;
  logic [SZ_W-1:0] dst_ptr_ff;
  logic [SZ_W-1:0] cell_ptr_ff;
  logic [SZ_W-1:0] byte_cnt_ff;
  logic [7:0] pattern_ff;
  dmac_state_t state_ff;
  logic req_ff;
  logic irq_ff;
  logic blk_pulse_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  // Applies a plain, clear, set or invert write to a stored word.
  function automatic logic [31:0] apply_write(input logic [31:0] old, input logic [31:0] wd,
                                              input dmac_wr_kind_t kind);
    logic [31:0] res;
    res = old;
    case (kind)
      DMAC_WR_PLAIN: res = wd;
      DMAC_WR_CLR: res = old & ~wd;
      DMAC_WR_SET: res = old | wd;
      DMAC_WR_INV: res = old ^ wd;
      default: res = old;
    endcase
    return res;
  endfunction

  // Bus decode: bits 3:2 select the alias, bits 15:4 the register.
  logic [15:0] base_addr;
  dmac_wr_kind_t wr_kind;
  logic wr_go;
  assign base_addr = {paddr[15:4], 4'h0};
  assign wr_kind = dmac_wr_kind_t'(paddr[3:2]);
  assign wr_go = psel & penable & pready_ff & pwrite;

  logic hit_ctrl, hit_int, hit_mask, hit_aux, hit_ssz, hit_dsz, hit_csz, hit_pat;
  logic hit_ro, mapped;
  assign hit_ctrl = base_addr == `DMAC_OFF_CTRL;
  assign hit_int = base_addr == `DMAC_OFF_INT_FLAGS;
  assign hit_mask = base_addr == `DMAC_OFF_INT_MASK;
  assign hit_aux = base_addr == `DMAC_OFF_AUX;
  assign hit_ssz = base_addr == `DMAC_OFF_SRC_SIZE;
  assign hit_dsz = base_addr == `DMAC_OFF_DST_SIZE;
  assign hit_csz = base_addr == `DMAC_OFF_CELL_SIZE;
  assign hit_pat = base_addr == `DMAC_OFF_PATTERN;
  assign hit_ro = (base_addr == `DMAC_OFF_SRC_PTR) | (base_addr == `DMAC_OFF_DST_PTR) |
                  (base_addr == `DMAC_OFF_CELL_PTR);
  assign mapped = hit_ctrl | hit_int | hit_mask | hit_aux | hit_ssz | hit_dsz | hit_csz | hit_pat | hit_ro;

  // Control word as software sees it; unimplemented bits stay zero.
  logic [31:0] ctl_word;
  always_comb begin
    ctl_word = `DMAC_RST_WORD;
    ctl_word[`DMAC_CTL_BUSY] = busy_ff | ctl_ff.channel_enable;
    ctl_word[`DMAC_CTL_CHNS] = ctl_ff.chain_direction_select;
    ctl_word[`DMAC_CTL_EN] = ctl_ff.channel_enable;
    ctl_word[`DMAC_CTL_AED] = ctl_ff.allow_events_while_disabled;
    ctl_word[`DMAC_CTL_CHN] = ctl_ff.chain_allow;
    ctl_word[`DMAC_CTL_AEN] = ctl_ff.auto_reenable;
    ctl_word[`DMAC_CTL_EDET] = edet_ff;
    ctl_word[`DMAC_CTL_PRI_HI:`DMAC_CTL_PRI_LO] = ctl_ff.channel_priority;
  end

  // Read mux; aliases read back the base register.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = `DMAC_RST_WORD;
    case (base_addr)
      `DMAC_OFF_CTRL: rd_word = ctl_word;
      `DMAC_OFF_INT_FLAGS: rd_word[`DMAC_INT_W-1:0] = flags_ff;
      `DMAC_OFF_INT_MASK: rd_word[`DMAC_INT_W-1:0] = mask_ff;
      `DMAC_OFF_AUX: rd_word[`DMAC_AUX_PAT_EN] = pat_en_ff;
      `DMAC_OFF_SRC_SIZE: rd_word[SZ_W-1:0] = src_size_ff;
      `DMAC_OFF_DST_SIZE: rd_word[SZ_W-1:0] = dst_size_ff;
      `DMAC_OFF_SRC_PTR: rd_word[SZ_W-1:0] = src_ptr_ff;
      `DMAC_OFF_DST_PTR: rd_word[SZ_W-1:0] = dst_ptr_ff;
      `DMAC_OFF_CELL_SIZE: rd_word[SZ_W-1:0] = cell_size_ff;
      `DMAC_OFF_CELL_PTR: rd_word[SZ_W-1:0] = cell_ptr_ff;
      `DMAC_OFF_PATTERN: rd_word[7:0] = pattern_ff;
      default: rd_word = `DMAC_RST_WORD;
    endcase
  end

  // APB answer: ready is raised for exactly the first access cycle, so every transfer takes two cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `DMAC_RST_WORD;
    end else if (psel && !penable) begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~mapped;
      prdata_ff <= (!pwrite && mapped) ? rd_word : `DMAC_RST_WORD;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // Events qualified by enable or by the allow-events bit.
  logic ev_ok, start_hit, abort_hit, chain_hit;
  assign ev_ok = ctl_ff.channel_enable | ctl_ff.allow_events_while_disabled;
  assign start_hit = start_event & ev_ok;
  assign abort_hit = abort_event & ev_ok;
  // Chaining only counts with chain allow set; the direction bit picks the neighbour.
  assign chain_hit = ctl_ff.chain_allow &
                     (ctl_ff.chain_direction_select ? chain_from_lower_done : chain_from_higher_done);

  // Completion terms of one byte move.
  logic move_done, pat_hit, blk_end, cell_end, err_hit;
  logic [SZ_W-1:0] blk_len, src_nxt, dst_nxt, cell_nxt, cnt_nxt;
  assign move_done = (state_ff == DMAC_MOVE) & move_rsp.done;
  assign err_hit = move_done & move_rsp.addr_err;
  assign blk_len = (src_size_ff > dst_size_ff) ? src_size_ff : dst_size_ff;
  assign src_nxt = src_ptr_ff + 1'b1;
  assign dst_nxt = dst_ptr_ff + 1'b1;
  assign cell_nxt = cell_ptr_ff + 1'b1;
  assign cnt_nxt = byte_cnt_ff + 1'b1;
  assign pat_hit = pat_en_ff & (move_rsp.data == pattern_ff);
  assign blk_end = move_done & ~move_rsp.addr_err & ((cnt_nxt == blk_len) | pat_hit);
  assign cell_end = move_done & ~move_rsp.addr_err & ((cell_nxt == cell_size_ff) | blk_end);

  // Control register: software write first, then hardware effects take precedence.
  logic [31:0] ctl_sw;
  always_comb begin
    ctl_sw = apply_write(ctl_word, pwdata, wr_kind) & `DMAC_CTL_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= '0;
    end else begin
      if (wr_go && hit_ctrl) begin
        ctl_ff.chain_direction_select <= ctl_sw[`DMAC_CTL_CHNS];
        ctl_ff.allow_events_while_disabled <= ctl_sw[`DMAC_CTL_AED];
        ctl_ff.chain_allow <= ctl_sw[`DMAC_CTL_CHN];
        ctl_ff.auto_reenable <= ctl_sw[`DMAC_CTL_AEN];
        ctl_ff.channel_priority <= ctl_sw[`DMAC_CTL_PRI_HI:`DMAC_CTL_PRI_LO];
      end
      // Abort, address error and a block end without auto re-enable switch the channel off.
      if (abort_hit || err_hit || (blk_end && !ctl_ff.auto_reenable)) begin
        ctl_ff.channel_enable <= 1'b0;
      end else if (chain_hit) begin
        ctl_ff.channel_enable <= 1'b1;
      end else if (wr_go && hit_ctrl) begin
        ctl_ff.channel_enable <= ctl_sw[`DMAC_CTL_EN];
      end
    end
  end

  // Event detected holds a recorded start until its cell is served, the transfer is aborted or an address error ends it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edet_ff <= 1'b0;
    end else if (start_hit) begin
      edet_ff <= 1'b1;
    end else if (cell_end || abort_hit || err_hit) begin
      edet_ff <= 1'b0;
    end
  end

  // Mover sequencing: one byte in flight at a time, and a move already issued always completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= DMAC_IDLE;
      req_ff <= 1'b0;
    end else begin
      case (state_ff)
        DMAC_IDLE: begin
          if (ctl_ff.channel_enable && edet_ff && !abort_hit) begin
            state_ff <= DMAC_MOVE;
            req_ff <= 1'b1;
          end
        end
        DMAC_MOVE: begin
          if (move_rsp.done) begin
            state_ff <= DMAC_IDLE;
            req_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= DMAC_IDLE;
          req_ff <= 1'b0;
        end
      endcase
    end
  end

  // Busy follows enable and the move in flight, so a cleared enable shows only once the move ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= ctl_ff.channel_enable | ((state_ff == DMAC_MOVE) & ~move_rsp.done);
    end
  end

  // Pointers: stepped per byte, wrapped at their size, zeroed at block end or abort.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ptr_ff <= '0;
      dst_ptr_ff <= '0;
      cell_ptr_ff <= '0;
      byte_cnt_ff <= '0;
    end else if (blk_end || abort_hit) begin
      src_ptr_ff <= '0;
      dst_ptr_ff <= '0;
      cell_ptr_ff <= '0;
      byte_cnt_ff <= '0;
    end else if (move_done && !move_rsp.addr_err) begin
      src_ptr_ff <= (src_nxt == src_size_ff) ? '0 : src_nxt;
      dst_ptr_ff <= (dst_nxt == dst_size_ff) ? '0 : dst_nxt;
      cell_ptr_ff <= cell_end ? '0 : cell_nxt;
      byte_cnt_ff <= cnt_nxt;
    end
  end

  // Each register's next word after a plain or alias write (for the flags, alias writes only); only the implemented low bits are kept below.
  logic [31:0] ssz_wr;
  logic [31:0] dsz_wr;
  logic [31:0] csz_wr;
  logic [31:0] pat_wr;
  logic [31:0] aux_wr;
  logic [31:0] mask_wr;
  logic [31:0] flg_wr;
  assign ssz_wr = apply_write({{(32-SZ_W){1'b0}}, src_size_ff}, pwdata, wr_kind);
  assign dsz_wr = apply_write({{(32-SZ_W){1'b0}}, dst_size_ff}, pwdata, wr_kind);
  assign csz_wr = apply_write({{(32-SZ_W){1'b0}}, cell_size_ff}, pwdata, wr_kind);
  assign pat_wr = apply_write({24'h0, pattern_ff}, pwdata, wr_kind);
  assign aux_wr = apply_write({31'h0, pat_en_ff}, pwdata, wr_kind);
  assign mask_wr = apply_write({{(32-`DMAC_INT_W){1'b0}}, mask_ff}, pwdata, wr_kind);
  assign flg_wr = apply_write({{(32-`DMAC_INT_W){1'b0}}, flags_ff}, pwdata, wr_kind);

  // Software-writable size, pattern and option registers; pointers are read-only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_size_ff <= '0;
      dst_size_ff <= '0;
      cell_size_ff <= '0;
      pattern_ff <= '0;
      pat_en_ff <= 1'b0;
      mask_ff <= '0;
    end else if (wr_go) begin
      if (hit_ssz) src_size_ff <= ssz_wr[SZ_W-1:0];
      if (hit_dsz) dst_size_ff <= dsz_wr[SZ_W-1:0];
      if (hit_csz) cell_size_ff <= csz_wr[SZ_W-1:0];
      if (hit_pat) pattern_ff <= pat_wr[7:0];
      if (hit_aux) pat_en_ff <= aux_wr[`DMAC_AUX_PAT_EN];
      if (hit_mask) mask_ff <= mask_wr[`DMAC_INT_W-1:0];
    end
  end

  // Hardware events of this cycle, in flag layout.
  logic [`DMAC_INT_W-1:0] hw_set;
  always_comb begin
    hw_set = '0;
    hw_set[`DMAC_INT_DD] = move_done & ~move_rsp.addr_err & (dst_nxt == dst_size_ff);
    hw_set[`DMAC_INT_DH] = move_done & ~move_rsp.addr_err & (dst_nxt == (dst_size_ff >> 1));
    hw_set[`DMAC_INT_BC] = blk_end;
    hw_set[`DMAC_INT_CC] = cell_end;
    hw_set[`DMAC_INT_TA] = abort_hit;
    hw_set[`DMAC_INT_AE] = err_hit;
  end

  // Flags: a plain write clears where ones are written; an event in the same cycle still wins.
  logic [`DMAC_INT_W-1:0] flags_sw;
  always_comb begin
    flags_sw = flags_ff;
    if (wr_go && hit_int) begin
      if (wr_kind == DMAC_WR_PLAIN) begin
        flags_sw = flags_ff & ~pwdata[`DMAC_INT_W-1:0];
      end else begin
        flags_sw = flg_wr[`DMAC_INT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= flags_sw | hw_set;
    end
  end

  // Registered outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
      blk_pulse_ff <= 1'b0;
    end else begin
      irq_ff <= |((flags_sw | hw_set) & mask_ff);
      blk_pulse_ff <= blk_end;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign move_req.valid = req_ff;
  assign move_req.source_pointer = src_ptr_ff;
  assign move_req.destination_pointer = dst_ptr_ff;
  assign channel_priority = ctl_ff.channel_priority;
  assign channel_busy = busy_ff;
  assign block_done_pulse = blk_pulse_ff;
  assign irq = irq_ff;

endmodule // dmac_channel
`default_nettype wire

// file: dmac_channel_bench.sv
// Self-checking bench for the DMA channel block: registers, moves, chaining and flags.
`timescale 1ns/1ns
`default_nettype none
`include "dmac_consts.svh"
module dmac_channel_bench
  import dmac_pkg::*;
;
  localparam logic [15:0] CT = `DMAC_OFF_CTRL;
  localparam logic [15:0] FL = `DMAC_OFF_INT_FLAGS;
  localparam logic [15:0] MK = `DMAC_OFF_INT_MASK;
  localparam logic [15:0] DP = `DMAC_OFF_DST_PTR;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic start_event = 1'b0, abort_event = 1'b0, chain_from_lower_done = 1'b0, chain_from_higher_done = 1'b0;
  logic mem_err = 1'b0;
  logic [3:0] mem_delay = 4'h3;
  logic [31:0] prdata, q;
  logic pready, pslverr, channel_busy, block_done_pulse, irq, e;
  logic [1:0] channel_priority;
  dmac_move_req_t move_req;
  dmac_move_rsp_t move_rsp;
  int num_errors = 0, num_checks = 0;
  int num_blk = 0;
  logic [15:0] regs [11] = '{CT, FL, MK, `DMAC_OFF_AUX, `DMAC_OFF_SRC_SIZE, `DMAC_OFF_DST_SIZE, `DMAC_OFF_SRC_PTR, DP,
    `DMAC_OFF_CELL_SIZE, `DMAC_OFF_CELL_PTR, `DMAC_OFF_PATTERN};
  logic [31:0] ch_ctl [6] = '{32'h20, 32'h20, 32'h120, 32'h120, 32'h100, 32'h0};
  logic [31:0] ch_exp [6] = '{32'h20, 32'h80a0, 32'h120, 32'h81a0, 32'h100, 32'h0};
  int ch_ev [6] = '{2, 3, 3, 2, 2, 3};
  dmac_channel u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_event, .abort_event,
    .chain_from_lower_done, .chain_from_higher_done, .move_rsp, .move_req, .channel_priority, .channel_busy,
    .block_done_pulse, .irq
  );
  dmac_mem_model u_mem (.pclk, .presetn, .move_req, .delay(mem_delay), .err(mem_err), .move_rsp);
  // Counts block end pulses so that the pulse output is judged against the number of blocks run.
  always @(posedge pclk) begin
    if (block_done_pulse === 1'b1) num_blk++;
  end
  // Clock of 4 ns period.
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen, and an idle edge follows so drivers never clash.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: no ready from the slave", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Pulses one event input for a single cycle.
  task automatic ev(input int k);
    case (k)
      0: start_event <= 1'b1;
      1: abort_event <= 1'b1;
      2: chain_from_lower_done <= 1'b1;
      default: chain_from_higher_done <= 1'b1;
    endcase
    @(posedge pclk);
    {start_event, abort_event, chain_from_lower_done, chain_from_higher_done} <= 4'h0;
    @(posedge pclk);
  endtask
  // Bounded wait for the interrupt; running out counts as a mismatch.
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog sized well above the expected run of a few hundred cycles.
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rc(regs[i], 32'h0);
    wr(CT, 32'hffffffff);
    rc(CT, 32'h000081f3);
    wr(CT, 32'h0);
    rc(CT, 32'h0);
    wr(CT, 32'h3);
    wr(CT + 16'h8, 32'h10);
    wr(CT + 16'h4, 32'h1);
    wr(CT + 16'hc, 32'h3);
    rc(CT, 32'h11);
    chk({30'h0, channel_priority}, 32'h1);
    apb(1'b0, 16'h3700, 32'h0);
    chk({e, q[30:0]}, 32'h80000000);
    wr(`DMAC_OFF_SRC_PTR, 32'hffff);
    rc(`DMAC_OFF_SRC_PTR, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(CT, ch_ctl[i]);
      ev(ch_ev[i]);
      rc(CT, ch_exp[i]);
    end
    wr(MK, 32'h0);
    ev(0);
    rc(CT, 32'h0);
    wr(CT, 32'h40);
    ev(0);
    rc(CT, 32'h44);
    ev(1);
    rc(FL, 32'h2);
    rc(CT, 32'h40);
    chk({31'h0, irq}, 32'h0);
    wr(MK, 32'h2);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(FL, 32'h3f);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`DMAC_OFF_SRC_SIZE, 32'h4);
    wr(`DMAC_OFF_DST_SIZE, 32'h4);
    wr(`DMAC_OFF_CELL_SIZE, 32'h2);
    wr(MK, 32'h3f);
    wr(CT, 32'h80);
    ev(0);
    wait_irq();
    rc(FL, 32'h14);
    rc(DP, 32'h2);
    rc(CT, 32'h8080);
    chk({31'h0, channel_busy}, 32'h1);
    wr(FL, 32'h3f);
    mem_delay <= 4'h0;
    ev(0);
    wait_irq();
    rc(FL, 32'h2c);
    rc(CT, 32'h0);
    chk({31'h0, channel_busy}, 32'h0);
    rc(DP, 32'h0);
    wr(FL, 32'h3f);
    wr(`DMAC_OFF_CELL_SIZE, 32'h4);
    wr(MK, 32'h8);
    wr(CT, 32'h90);
    ev(0);
    wait_irq();
    rc(FL, 32'h3c);
    rc(CT, 32'h8090);
    wr(CT, 32'h0);
    wr(FL, 32'h3f);
    mem_err <= 1'b1;
    wr(MK, 32'h1);
    wr(CT, 32'h80);
    ev(0);
    wait_irq();
    rc(FL, 32'h1);
    rc(CT, 32'h0);
    rc(DP, 32'h0);
    wr(FL, 32'h3f);
    mem_err <= 1'b0;
    wr(`DMAC_OFF_AUX, 32'h1);
    wr(`DMAC_OFF_PATTERN, 32'h1);
    wr(MK, 32'h8);
    wr(CT, 32'h80);
    ev(0);
    wait_irq();
    rc(FL, 32'h1c);
    rc(CT, 32'h0);
    chk(num_blk, 32'h3);
    print_verdict();
  end
endmodule // dmac_channel_bench
`default_nettype wire

// file: dmac_channel_props.sv
// Port-level assertions for the DMA channel block and its bind.
`timescale 1ns/1ns
`default_nettype none
`include "dmac_consts.svh"
module dmac_channel_props
  import dmac_pkg::*;
#(
  parameter int SZ_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_event,
  input wire logic abort_event,
  input wire logic chain_from_lower_done,
  input wire logic chain_from_higher_done,
  input wire dmac_move_rsp_t move_rsp,
  input wire dmac_move_req_t move_req,
  input wire logic [1:0] channel_priority,
  input wire logic channel_busy,
  input wire logic block_done_pulse,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Control accesses are decoded here so that the properties stay short; read data is judged in the answer cycle.
  logic rd_ctl;
  logic wr_ctl;
  logic [1:0] wr_pri;
  logic [15:0] dptr;
  assign rd_ctl = pready && !pwrite && paddr == `DMAC_OFF_CTRL;
  assign wr_ctl = psel && penable && pready && pwrite && paddr == `DMAC_OFF_CTRL;
  assign wr_pri = pwdata[1:0];
  assign dptr = move_req.destination_pointer;
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("setup not answered in the next cycle");
  property p_ctl_zero; rd_ctl |-> prdata[31:16] == 16'h0 && prdata[14:9] == 6'h0 && !prdata[3]; endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("unused control bits read nonzero");
  property p_busy_en; rd_ctl && prdata[7] |-> prdata[15]; endproperty
  a_busy_en: assert property (p_busy_en) else $error("enabled channel reads not busy");
  property p_prio; wr_ctl |=> channel_priority == $past(wr_pri); endproperty
  a_prio: assert property (p_prio) else $error("priority output differs from written field");
  property p_busy_move; move_req.valid |-> channel_busy; endproperty
  a_busy_move: assert property (p_busy_move) else $error("move in flight without busy");
  property p_drop; move_req.valid && move_rsp.done |=> !move_req.valid; endproperty
  a_drop: assert property (p_drop) else $error("request not withdrawn after done");
  property p_step; move_req.valid && move_rsp.done && !move_rsp.addr_err |=> dptr == $past(dptr) + 16'h1 || dptr == 16'h0;
  endproperty
  a_step: assert property (p_step) else $error("destination pointer did not step by one");
  property p_blk; block_done_pulse |=> !block_done_pulse; endproperty
  a_blk: assert property (p_blk) else $error("block done pulse longer than one cycle");
  // Main scenarios that the bench is meant to reach.
  c_blk: cover property (block_done_pulse);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule // dmac_channel_props
bind dmac_channel dmac_channel_props #(.SZ_W(SZ_W)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_event, .abort_event,
  .chain_from_lower_done, .chain_from_higher_done, .move_rsp, .move_req, .channel_priority, .channel_busy,
  .block_done_pulse, .irq
);
`default_nettype wire

// file: dmac_consts.svh
// Register offsets, field positions and reset values of the DMA channel control block.
`ifndef DMAC_CONSTS_SVH
`define DMAC_CONSTS_SVH
`define DMAC_OFF_CTRL 16'h3580
`define DMAC_OFF_INT_FLAGS 16'h3590
`define DMAC_OFF_INT_MASK 16'h35a0
`define DMAC_OFF_AUX 16'h35b0
`define DMAC_OFF_SRC_SIZE 16'h35f0
`define DMAC_OFF_DST_SIZE 16'h3600
`define DMAC_OFF_SRC_PTR 16'h3610
`define DMAC_OFF_DST_PTR 16'h3620
`define DMAC_OFF_CELL_SIZE 16'h3630
`define DMAC_OFF_CELL_PTR 16'h3640
`define DMAC_OFF_PATTERN 16'h3650
`define DMAC_ALIAS_CLR 2'h1
`define DMAC_ALIAS_SET 2'h2
`define DMAC_ALIAS_INV 2'h3
`define DMAC_CTL_BUSY 15
`define DMAC_CTL_CHNS 8
`define DMAC_CTL_EN 7
`define DMAC_CTL_AED 6
`define DMAC_CTL_CHN 5
`define DMAC_CTL_AEN 4
`define DMAC_CTL_EDET 2
`define DMAC_CTL_PRI_HI 1
`define DMAC_CTL_PRI_LO 0
`define DMAC_CTL_WMASK 32'h000001f3
`define DMAC_INT_DD 5
`define DMAC_INT_DH 4
`define DMAC_INT_BC 3
`define DMAC_INT_CC 2
`define DMAC_INT_TA 1
`define DMAC_INT_AE 0
`define DMAC_INT_W 6
`define DMAC_AUX_PAT_EN 0
`define DMAC_RST_WORD 32'h00000000
`endif

// file: dmac_mem_model.sv
// Stand-in for the system bus memories: answers each byte move after a set delay.
`timescale 1ns/1ns
`default_nettype none
module dmac_mem_model
  import dmac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dmac_move_req_t move_req,
  input wire logic [3:0] delay,
  input wire logic err,
  output dmac_move_rsp_t move_rsp
);
  logic [3:0] wait_ff;
  logic done_ff;
  // Done is one cycle; the request still standing in the next cycle must not be answered twice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (move_req.valid && !done_ff) begin
        wait_ff <= (wait_ff == delay) ? 4'h0 : wait_ff + 4'h1;
        done_ff <= (wait_ff == delay);
      end
    end
  end
  // Away from done the data and error lines show no stale value, so a late sample is caught.
  assign move_rsp.done = done_ff;
  assign move_rsp.addr_err = done_ff ? err : ~err;
  assign move_rsp.data = done_ff ? move_req.source_pointer[7:0] : ~move_req.source_pointer[7:0];
endmodule // dmac_mem_model
`default_nettype wire

// file: dmac_pkg.sv
// Types shared by the DMA channel control block.
package dmac_pkg;
  typedef enum logic [1:0] {DMAC_WR_PLAIN, DMAC_WR_CLR, DMAC_WR_SET, DMAC_WR_INV} dmac_wr_kind_t;
  typedef enum {DMAC_IDLE, DMAC_MOVE} dmac_state_t;
  typedef struct packed {
    logic chain_direction_select;
    logic channel_enable;
    logic allow_events_while_disabled;
    logic chain_allow;
    logic auto_reenable;
    logic [1:0] channel_priority;
  } dmac_ctl_t;
  typedef struct packed {
    logic valid;
    logic [15:0] source_pointer;
    logic [15:0] destination_pointer;
  } dmac_move_req_t;
  typedef struct packed {
    logic done;
    logic addr_err;
    logic [7:0] data;
  } dmac_move_rsp_t;
endpackage
